// *** shared/dcs_pkg.sv ***
package dcs_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_DATA  = 8'h08;
  localparam logic [7:0] A_WC    = 8'h0C;
  localparam logic [7:0] A_BA    = 8'h10;
  localparam logic [7:0] A_DA    = 8'h14;
  localparam logic [7:0] A_DS    = 8'h18;
  localparam logic [7:0] A_SPARE = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C_GO     = 0;
  localparam int C_FN     = 1;
  localparam int C_TYPE   = 4;
  localparam int C_BADPAR = 5;
  localparam int C_CCLR   = 6;
  localparam int C_DCLR   = 7;

  localparam int S_ORDY  = 0;
  localparam int S_IRDY  = 1;
  localparam int S_DLATE = 2;
  localparam int S_CONTROLLER_ERROR_FLAG  = 3;
  localparam int S_LPAR  = 4;
  localparam int S_PGE   = 5;
  localparam int S_WCE   = 6;
  localparam int S_NXM   = 7;
  localparam int S_COE   = 8;
  localparam int S_ECH   = 9;
  localparam int S_IDA   = 10;
  localparam int S_DTE   = 11;
  localparam int S_BUSY  = 12;

  localparam int D_ATTN  = 0;
  localparam int D_CATTN = 1;
  localparam int D_DINT  = 2;
  localparam int D_SV    = 3;
  localparam int D_DPE   = 4;
  localparam int D_SINC  = 5;

  // Disk address: sector [4:0], head [7:5], cylinder [17:8].
  localparam int DA_SEC  = 0;
  localparam int DA_HEAD = 5;
  localparam int DA_CYL  = 8;

  // ----------------------------------------------------------------
  // Geometry, sizes and timing
  // ----------------------------------------------------------------
  localparam int SILO_DEPTH   = 66;
  localparam int SECTOR_WORDS = 256;
  localparam int HEADS        = 3;
  localparam int SECTORS      = 22;
  localparam int MAX_CYL      = 411;
  localparam int SINC_HEAD_A  = 3;
  localparam int SINC_HEAD_B  = 7;
  localparam logic [31:0] RST_VAL = 32'h0;

  localparam int CLK_PS    = 4000;
  localparam int SEEK_NS   = 2000;
  localparam int RECAL_NS  = 4000;
  localparam int SEEK_CYC  = (SEEK_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RECAL_CYC = (RECAL_NS * 1000 + CLK_PS - 1) / CLK_PS;

  typedef enum logic [2:0] {FN_SELECT, FN_RECAL, FN_SEEK, FN_READ, FN_WRITE, FN_WCHK} dcs_fn_t;

endpackage

// *** rtl/dcs_ctrl.sv ***
`timescale 1ns/1ps
// Functional notes
// [R01] Reading the empty buffer sets data late and controller error; clear resets both.
// [R02] One word written into empty buffer raises output ready.
// [R03] Reading that word back leaves input ready, no output ready, no errors.
// [R04] Buffer holds 66 words with correct ready and late status throughout.
// [R05] A 67th write into full buffer raises data late; earlier writes never do.
// [R06] Controller clear returns input and output ready to the empty state.
// [R07] Drive type mismatch sets drive type error and status valid.
// [R08] Select with bad parity sets link parity, error, attentions, interrupt, status valid.
// [R09] Controller clear keeps drive interrupt and attention; only drive clear clears attention.
// [R10] Good parity reselect keeps attention flags set and clears link parity error.
// [R11] Recalibrate gives two interrupts: status valid set at first, cleared at second.
// [R12] Seek to a legal cylinder raises exactly one attention interrupt.
// [R13] Heads 3 to 7 are illegal addresses; heads 3 and 7 also flag seek incomplete.
// [R14] Cylinder beyond the last one is an illegal disk address.
// [R15] A short write zero-fills the rest of its sector.
// [R16] Write check mismatch sets error; address and count point at the failing word.
// [R17] Write check compares only the requested word count.
// [R18] Long transfers continue into following sectors; a write's final partial sector is zero-filled.
// [R19] Running past the last sector of the pack sets cylinder overflow.
// [R20] Writing the spare register during a transfer sets programming error.
// [R21] Reading a sector whose write was cut by controller clear sets ECC hard error.
// [R22] A memory access answered with an error sets non-existent memory.
// [R23] Buffer returns words in write order; controller clear empties it.
module dcs_ctrl #(
  parameter int SILO_DEPTH = dcs_pkg::SILO_DEPTH,
  parameter int MAX_CYL    = dcs_pkg::MAX_CYL
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        drv_type_pin,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [21:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  input  wire logic [15:0] mem_rdata,
  output logic             dsk_req,
  output logic             dsk_we,
  output logic      [25:0] dsk_addr,
  output logic      [15:0] dsk_wdata,
  input  wire logic        dsk_ack,
  input  wire logic [15:0] dsk_rdata,
  output logic             drv_irq
);

  localparam int PW = $clog2(SILO_DEPTH);
  localparam int CW = $clog2(SILO_DEPTH + 1);
  localparam int WW = $clog2(dcs_pkg::SECTOR_WORDS);

  typedef enum logic [2:0] {X_IDLE, X_WAIT, X_RECAL2, X_MEM, X_DSK, X_FILL} dcs_xs_t;

  typedef struct packed {
    logic [SILO_DEPTH-1:0][15:0] silo;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
    logic                        dlate, controller_error_flag, lpar, pge, wce, nxm, cylinder_overflow_error, ech, ida, dte;
    logic                        attn, cattn, dint, sv, drive_parity_error, sinc;
    dcs_pkg::dcs_fn_t            fn;
    dcs_xs_t                     xs;
    logic [15:0]                 tmr, wc, spare, dat;
    logic [21:0]                 ba;
    logic [9:0]                  cyl;
    logic [2:0]                  head;
    logic [4:0]                  sec;
    logic [WW-1:0]               widx;
    logic                        torn_v;
    logic [17:0]                 torn_da;
    logic                        pready, pslverr;
    logic [31:0]                 prdata;
    logic                        mem_req, mem_we, dsk_req, dsk_we, irq, typ_s1, typ_s2;
  } dcs_state_t;

  dcs_state_t       s;
  dcs_state_t       n;
  logic             access;
  logic             wr_done;
  logic             rd_done;
  logic             hi_ok;
  logic             map;
  logic             cmd_wr;
  logic             cclr;
  logic             dclr;
  logic             go;
  logic             data_wr;
  logic             data_rd;
  logic             bad_da;
  logic [17:0]      da_cur;
  logic [PW:0]      wi;
  logic [31:0]      rd;
  dcs_pkg::dcs_fn_t fn_in;

  // ----------------------------------------------------------------
  // Word step: pointers advance, sectors roll over, end of pack stops.
  // ----------------------------------------------------------------
  function automatic dcs_state_t adv(input dcs_state_t a);
    dcs_state_t r;
    logic       last;
    r = a;
    last = 1'b0;
    r.ba = a.ba + 22'h2;
    r.wc = a.wc - 16'h1;
    r.widx = a.widx + WW'(1);
    if (r.widx == '0) begin
      if (a.fn == dcs_pkg::FN_WRITE && a.torn_da == {a.cyl, a.head, a.sec}) begin
        r.torn_v = 1'b0;
      end
      last = a.sec == 5'(dcs_pkg::SECTORS - 1) && a.head == 3'(dcs_pkg::HEADS - 1) && a.cyl == 10'(MAX_CYL);
      if (!last && a.sec == 5'(dcs_pkg::SECTORS - 1)) begin // [R18]
        r.sec = 5'h0;
        r.head = (a.head == 3'(dcs_pkg::HEADS - 1)) ? 3'h0 : a.head + 3'h1;
        if (a.head == 3'(dcs_pkg::HEADS - 1)) begin
          r.cyl = a.cyl + 10'h1;
        end
      end else if (!last) begin
        r.sec = a.sec + 5'h1;
      end
    end
    if (r.wc == 16'h0) begin
      r.xs = (a.fn == dcs_pkg::FN_WRITE && r.widx != '0) ? X_FILL : X_IDLE; // [R15] [R18]
      r.dat = 16'h0;
    end else if (last) begin
      r.cylinder_overflow_error = 1'b1; // [R19]
      r.controller_error_flag = 1'b1;
      r.xs = X_IDLE;
    end else begin
      r.xs = (a.fn == dcs_pkg::FN_READ) ? X_DSK : X_MEM;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign access  = psel && penable;
  assign wr_done = access && s.pready && pwrite;
  assign rd_done = access && s.pready && !pwrite;
  assign hi_ok   = paddr[11:8] == 4'h0;
  assign cmd_wr  = wr_done && hi_ok && paddr[7:0] == dcs_pkg::A_CMD;
  assign cclr    = cmd_wr && pwdata[dcs_pkg::C_CCLR];
  assign dclr    = cmd_wr && pwdata[dcs_pkg::C_DCLR];
  assign go      = cmd_wr && pwdata[dcs_pkg::C_GO] && s.xs == X_IDLE && !cclr;
  assign data_wr = wr_done && hi_ok && paddr[7:0] == dcs_pkg::A_DATA;
  assign data_rd = rd_done && hi_ok && paddr[7:0] == dcs_pkg::A_DATA;
  assign fn_in   = dcs_pkg::dcs_fn_t'(pwdata[dcs_pkg::C_FN +: 3]);
  assign da_cur  = {s.cyl, s.head, s.sec};
  assign bad_da  = s.head >= 3'(dcs_pkg::HEADS) || s.cyl > 10'(MAX_CYL) || s.sec >= 5'(dcs_pkg::SECTORS);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.irq = 1'b0;
    n.typ_s1 = drv_type_pin;
    n.typ_s2 = s.typ_s1;
    rd = dcs_pkg::RST_VAL;
    map = 1'b1;
    wi = {1'b0, s.rp} + (PW + 1)'(s.cnt);
    if (wi >= (PW + 1)'(SILO_DEPTH)) begin
      wi = wi - (PW + 1)'(SILO_DEPTH);
    end
    case (paddr[7:0])
      dcs_pkg::A_CMD: rd[dcs_pkg::C_FN +: 3] = s.fn;
      dcs_pkg::A_STAT: begin
        rd[dcs_pkg::S_ORDY]  = s.cnt != '0;
        rd[dcs_pkg::S_IRDY]  = s.cnt != CW'(SILO_DEPTH);
        rd[dcs_pkg::S_DLATE] = s.dlate;
        rd[dcs_pkg::S_CONTROLLER_ERROR_FLAG]  = s.controller_error_flag;
        rd[dcs_pkg::S_LPAR]  = s.lpar;
        rd[dcs_pkg::S_PGE]   = s.pge;
        rd[dcs_pkg::S_WCE]   = s.wce;
        rd[dcs_pkg::S_NXM]   = s.nxm;
        rd[dcs_pkg::S_COE]   = s.cylinder_overflow_error;
        rd[dcs_pkg::S_ECH]   = s.ech;
        rd[dcs_pkg::S_IDA]   = s.ida;
        rd[dcs_pkg::S_DTE]   = s.dte;
        rd[dcs_pkg::S_BUSY]  = s.xs != X_IDLE;
      end
      dcs_pkg::A_DATA:  rd[15:0] = (s.cnt != '0) ? s.silo[s.rp] : 16'h0;
      dcs_pkg::A_WC:    rd[15:0] = s.wc;
      dcs_pkg::A_BA:    rd[21:0] = s.ba;
      dcs_pkg::A_DA:    rd[17:0] = da_cur;
      dcs_pkg::A_DS: begin
        rd[dcs_pkg::D_ATTN]  = s.attn;
        rd[dcs_pkg::D_CATTN] = s.cattn;
        rd[dcs_pkg::D_DINT]  = s.dint;
        rd[dcs_pkg::D_SV]    = s.sv;
        rd[dcs_pkg::D_DPE]   = s.drive_parity_error;
        rd[dcs_pkg::D_SINC]  = s.sinc;
      end
      dcs_pkg::A_SPARE: rd[15:0] = s.spare;
      default:          map = 1'b0;
    endcase
    // One wait state: the answer is registered so every bus output is a flop.
    n.pready = access && !s.pready;
    n.pslverr = access && !s.pready && !(hi_ok && map);
    if (access && !s.pready) begin
      n.prdata = (hi_ok && map) ? rd : dcs_pkg::RST_VAL;
    end

    // Buffer push and pop.
    if (data_wr) begin
      if (s.cnt == CW'(SILO_DEPTH)) begin
        n.dlate = 1'b1; // [R05]
        n.controller_error_flag = 1'b1;
      end else begin
        n.silo[wi[PW-1:0]] = pwdata[15:0]; // [R02] [R04] [R23]
        n.cnt = s.cnt + CW'(1);
      end
    end
    if (data_rd) begin
      if (s.cnt == '0) begin
        n.dlate = 1'b1; // [R01]
        n.controller_error_flag = 1'b1;
      end else begin
        n.rp = (s.rp == PW'(SILO_DEPTH - 1)) ? '0 : s.rp + PW'(1); // [R03] [R23]
        n.cnt = s.cnt - CW'(1);
      end
    end

    // Plain registers; transfer parameters are frozen while busy.
    if (wr_done && hi_ok && s.xs == X_IDLE) begin
      case (paddr[7:0])
        dcs_pkg::A_WC: n.wc = pwdata[15:0];
        dcs_pkg::A_BA: n.ba = pwdata[21:0];
        dcs_pkg::A_DA: begin
          n.sec = pwdata[dcs_pkg::DA_SEC +: 5];
          n.head = pwdata[dcs_pkg::DA_HEAD +: 3];
          n.cyl = pwdata[dcs_pkg::DA_CYL +: 10];
        end
        dcs_pkg::A_SPARE: n.spare = pwdata[15:0];
        default: ;
      endcase
    end
    if (wr_done && hi_ok && paddr[7:0] == dcs_pkg::A_SPARE && s.xs != X_IDLE) begin
      n.pge = 1'b1; // [R20]
      n.controller_error_flag = 1'b1;
    end

    // Controller clear: buffer and errors reset, drive flags survive.
    if (cclr) begin
      n.cnt = '0; // [R06] [R23] [R01]
      n.rp = '0;
      {n.dlate, n.controller_error_flag, n.lpar, n.pge, n.wce, n.nxm, n.cylinder_overflow_error, n.ech, n.ida, n.dte} = '0;
      if (s.fn == dcs_pkg::FN_WRITE && (s.xs == X_MEM || s.xs == X_DSK || s.xs == X_FILL)) begin
        n.torn_v = 1'b1; // [R21]
        n.torn_da = da_cur;
      end
      n.xs = X_IDLE;
      n.mem_req = 1'b0;
      n.dsk_req = 1'b0;
    end
    if (dclr) begin
      {n.attn, n.cattn, n.dint, n.drive_parity_error, n.sinc} = '0; // [R09]
    end

    // Command start.
    if (go) begin
      n.fn = fn_in;
      case (fn_in)
        dcs_pkg::FN_SELECT: begin
          n.sv = 1'b1;
          if (pwdata[dcs_pkg::C_BADPAR]) begin
            {n.lpar, n.controller_error_flag, n.cattn, n.attn, n.drive_parity_error, n.dint, n.irq} = '1; // [R08]
          end else begin
            n.lpar = 1'b0; // [R10] [R11]
          end
          if (s.typ_s2 != pwdata[dcs_pkg::C_TYPE]) begin
            n.dte = 1'b1; // [R07]
            n.controller_error_flag = 1'b1;
          end
        end
        dcs_pkg::FN_RECAL: begin
          n.tmr = 16'(dcs_pkg::RECAL_CYC);
          n.xs = X_WAIT;
        end
        dcs_pkg::FN_SEEK: begin
          if (bad_da) begin
            n.ida = 1'b1; // [R13] [R14]
            n.controller_error_flag = 1'b1;
            n.sinc = s.head == 3'(dcs_pkg::SINC_HEAD_A) || s.head == 3'(dcs_pkg::SINC_HEAD_B);
          end else begin
            n.tmr = 16'(dcs_pkg::SEEK_CYC);
            n.xs = X_WAIT;
          end
        end
        dcs_pkg::FN_READ, dcs_pkg::FN_WRITE, dcs_pkg::FN_WCHK: begin
          if (bad_da) begin
            n.ida = 1'b1; // [R14]
            n.controller_error_flag = 1'b1;
          end else if (s.wc != 16'h0) begin
            n.widx = '0;
            n.xs = (fn_in == dcs_pkg::FN_READ) ? X_DSK : X_MEM;
          end
        end
        default: ;
      endcase
    end

    // Sequencer; a controller clear in the same cycle has already stopped it.
    if (!cclr) begin
      unique case (s.xs)
        X_IDLE: ;
        X_WAIT: begin
          if (s.tmr != 16'h0) begin
            n.tmr = s.tmr - 16'h1;
          end else if (s.fn == dcs_pkg::FN_RECAL) begin
            n.irq = 1'b1; // [R11]
            n.dint = 1'b1;
            n.sv = 1'b1;
            n.tmr = 16'(dcs_pkg::RECAL_CYC);
            n.xs = X_RECAL2;
          end else begin
            n.irq = 1'b1; // [R12]
            {n.attn, n.cattn, n.dint} = '1;
            n.xs = X_IDLE;
          end
        end
        X_RECAL2: begin
          if (s.tmr != 16'h0) begin
            n.tmr = s.tmr - 16'h1;
          end else begin
            n.irq = 1'b1; // [R11]
            n.sv = 1'b0;
            {n.attn, n.cattn, n.dint} = '1;
            n.cyl = '0;
            n.xs = X_IDLE;
          end
        end
        X_MEM: begin
          if (s.mem_req && mem_ack) begin
            n.mem_req = 1'b0;
            if (mem_err) begin
              n.nxm = 1'b1; // [R22]
              n.controller_error_flag = 1'b1;
              n.xs = X_IDLE;
            end else if (s.fn == dcs_pkg::FN_READ) begin
              n = adv(n);
            end else begin
              n.dat = mem_rdata;
              n.xs = X_DSK;
            end
          end else begin
            n.mem_req = 1'b1;
            n.mem_we = s.fn == dcs_pkg::FN_READ;
          end
        end
        X_DSK: begin
          if (s.fn == dcs_pkg::FN_READ && s.widx == '0 && !s.dsk_req && s.torn_v && s.torn_da == da_cur) begin
            n.ech = 1'b1; // [R21]
            n.controller_error_flag = 1'b1;
            n.xs = X_IDLE;
          end else if (s.dsk_req && dsk_ack) begin
            n.dsk_req = 1'b0;
            if (s.fn == dcs_pkg::FN_READ) begin
              n.dat = dsk_rdata;
              n.xs = X_MEM;
            end else if (s.fn == dcs_pkg::FN_WCHK && dsk_rdata != s.dat) begin
              n.wce = 1'b1; // [R16]
              n.controller_error_flag = 1'b1;
              n.xs = X_IDLE;
            end else begin
              n = adv(n); // [R17] [R18] [R19]
            end
          end else begin
            n.dsk_req = 1'b1;
            n.dsk_we = s.fn == dcs_pkg::FN_WRITE;
          end
        end
        X_FILL: begin
          if (s.dsk_req && dsk_ack) begin
            n.dsk_req = 1'b0;
            n.widx = s.widx + WW'(1); // [R15] [R18]
            if (n.widx == '0) begin
              n.xs = X_IDLE;
              n.torn_v = s.torn_v && s.torn_da != da_cur;
            end
          end else begin
            n.dsk_req = 1'b1;
            n.dsk_we = 1'b1;
          end
        end
        default: n.xs = X_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign mem_req   = s.mem_req;
  assign mem_we    = s.mem_we;
  assign mem_addr  = s.ba;
  assign mem_wdata = s.dat;
  assign dsk_req   = s.dsk_req;
  assign dsk_we    = s.dsk_we;
  assign dsk_addr  = {s.cyl, s.head, s.sec, s.widx};
  assign dsk_wdata = s.dat;
  assign drv_irq   = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dcs_cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_empty_read_late: assert property (data_rd && s.cnt == '0 |=> s.dlate && s.controller_error_flag) // [R01]
    else $error("empty buffer read did not flag data late");
  a_first_word_rdy: assert property (data_wr && s.cnt == '0 |=> s.cnt == CW'(1) ##1 s.cnt != '0) // [R02]
    else $error("first buffer word did not raise output ready");
  a_last_word_read: assert property (data_rd && s.cnt == CW'(1) && !s.dlate |=> s.cnt == '0 && !s.dlate && !s.controller_error_flag) // [R03]
    else $error("last buffer word read left wrong status");
  a_no_early_late: assert property (data_wr && s.cnt < CW'(SILO_DEPTH) && !s.dlate |=> !s.dlate) // [R04]
    else $error("data late raised before buffer full");
  a_full_write_late: assert property (data_wr && s.cnt == CW'(SILO_DEPTH) |=> s.dlate && $stable(s.cnt)) // [R05]
    else $error("write into full buffer not flagged");
  a_clear_empties: assert property (cclr |=> s.cnt == '0 && !s.dlate && !s.controller_error_flag && s.xs == X_IDLE) // [R06]
    else $error("controller clear did not reset buffer");
  a_clear_keeps_attn: assert property (cclr && !dclr && s.attn && s.dint |=> s.attn && s.dint) // [R09]
    else $error("controller clear lost attention");
  a_bad_parity: assert property (go && fn_in == dcs_pkg::FN_SELECT && pwdata[dcs_pkg::C_BADPAR]
    |=> s.lpar && s.controller_error_flag && s.cattn && s.drive_parity_error && s.sv && drv_irq) // [R08]
    else $error("bad parity select flags missing");
  a_bad_head: assert property (go && fn_in == dcs_pkg::FN_SEEK && s.head >= 3'(dcs_pkg::HEADS) |=> s.ida) // [R13]
    else $error("illegal head not flagged");
  a_recal_second: assert property (s.xs == X_RECAL2 && s.tmr == 16'h0 && !cclr |=> drv_irq && !s.sv) // [R11]
    else $error("second recalibrate interrupt wrong");
  a_prog_error: assert property (wr_done && hi_ok && paddr[7:0] == dcs_pkg::A_SPARE && s.xs != X_IDLE |=> s.pge) // [R20]
    else $error("spare write during transfer not flagged");
  a_nxm_stops: assert property (s.xs == X_MEM && s.mem_req && mem_ack && mem_err && !cclr
    |=> s.nxm && s.xs == X_IDLE && !mem_req) // [R22]
    else $error("missing memory not flagged");
  a_fill_zero: assert property (s.xs == X_FILL && s.dsk_req |-> s.dsk_we && s.dat == 16'h0) // [R15]
    else $error("sector fill not zero");

  c_silo_overrun: cover property (data_wr && s.cnt == CW'(SILO_DEPTH));
  c_overflow: cover property (!s.cylinder_overflow_error ##1 s.cylinder_overflow_error);
  c_check_error: cover property (!s.wce ##1 s.wce);
  c_recal_done: cover property (s.xs == X_RECAL2 ##1 s.xs == X_IDLE);

endmodule

// *** dv/dcs_mem_disk.sv ***
`timescale 1ns/1ps
// ------------------------------------
// Host memory and drive, random 0..2 wait.
// ------------------------------------
module dcs_mem_disk #(
  parameter int NXM_BASE = 32'h3F000
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [21:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic             mem_err,
  output logic      [15:0] mem_rdata,
  input  wire logic        dsk_req,
  input  wire logic        dsk_we,
  input  wire logic [25:0] dsk_addr,
  input  wire logic [15:0] dsk_wdata,
  output logic             dsk_ack,
  output logic      [15:0] dsk_rdata
);
  logic [15:0] mem [int];
  logic [15:0] dsk [int];
  int          cm, cd, lm, ld;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {mem_ack, mem_err, dsk_ack, mem_rdata, dsk_rdata, cm, cd, lm, ld} <= 0;
    end else begin
      // Released data lines toggle so a stale word never looks valid.
      mem_ack <= 0;
      mem_err <= 0;
      dsk_ack <= 0;
      mem_rdata <= ~mem_rdata;
      dsk_rdata <= ~dsk_rdata;
      cm <= (mem_req && !mem_ack) ? cm + 1 : 0;
      cd <= (dsk_req && !dsk_ack) ? cd + 1 : 0;
      if (mem_req && !mem_ack && cm >= lm) begin
        mem_ack <= 1;
        lm <= $urandom % 3;
        mem_err <= mem_addr >= NXM_BASE;
        if (mem_we) mem[mem_addr] = mem_wdata;
        else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 16'h0;
      end
      if (dsk_req && !dsk_ack && cd >= ld) begin
        dsk_ack <= 1;
        ld <= $urandom % 3;
        if (dsk_we) dsk[dsk_addr] = dsk_wdata;
        else dsk_rdata <= dsk.exists(dsk_addr) ? dsk[dsk_addr] : 16'h0;
      end
    end
  end
endmodule

// *** dv/dcs_ctrl_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module dcs_ctrl_tb;
  // ------------------------------------
  // Bench signals
  // ------------------------------------
  logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, drv_type_pin = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, mem_req, mem_we, mem_ack, mem_err, dsk_req, dsk_we, dsk_ack, drv_irq, err;
  logic [21:0] mem_addr;
  logic [25:0] dsk_addr;
  logic [15:0] mem_wdata, mem_rdata, dsk_wdata, dsk_rdata, q[$];
  int failures = 0, n_compared = 0, irqs = 0, i, k;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (drv_irq === 1'b1) irqs <= irqs + 1;
  dcs_ctrl #(.MAX_CYL(dcs_pkg::MAX_CYL)) i_dcs_ctrl (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .drv_type_pin, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_err, .mem_rdata, .dsk_req, .dsk_we, .dsk_addr, .dsk_wdata, .dsk_ack, .dsk_rdata, .drv_irq);
  dcs_mem_disk i_dcs_mem_disk (.mclk, .rstn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_err, .mem_rdata, .dsk_req, .dsk_we, .dsk_addr, .dsk_wdata, .dsk_ack, .dsk_rdata);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 0);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {4'h0, a}; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic go(input logic [31:0] c);
    apb(1, dcs_pkg::A_CMD, c);
    do apb(0, dcs_pkg::A_STAT); while (rd[12] !== 1'b0);
  endtask
  task automatic xfer(input logic [31:0] ba, wc, input int fn, pge = 0, da = 312 << 8);
    apb(1, dcs_pkg::A_WC, wc);
    apb(1, dcs_pkg::A_BA, ba);
    apb(1, dcs_pkg::A_DA, da);
    apb(1, dcs_pkg::A_CMD, fn * 2 + 1);
    // Spare write lands while the transfer is still busy.
    if (pge) apb(1, dcs_pkg::A_SPARE, 1);
    do apb(0, dcs_pkg::A_STAT); while (rd[12] !== 1'b0);
  endtask
  task automatic fill(input int n);
    for (i = 0; i < n; i++) begin
      q.push_back(16'($urandom));
      apb(1, dcs_pkg::A_DATA, {16'h0, q[$]});
      apb(0, dcs_pkg::A_STAT);
      `CHK(rd[2:0], {i >= 66, i < 65, 1'b1})
    end
  endtask
  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    failures++;
    test_done;
  end
  initial begin
    void'($urandom(30897));
    repeat (6) @(posedge mclk);
    rstn <= 1;
    go(32'h40); apb(0, dcs_pkg::A_DATA); apb(0, dcs_pkg::A_STAT);
    `CHK(rd[3:2], 2'b11)
    go(32'h40); apb(0, dcs_pkg::A_STAT);
    `CHK(rd[3:0], 4'h2)
    fill(66);
    for (i = 0; i < 66; i++) begin
      apb(0, dcs_pkg::A_DATA);
      `CHK(rd[15:0], q.pop_front())
      apb(0, dcs_pkg::A_STAT);
      `CHK(rd[3:0], {3'b001, i < 65})
    end
    apb(0, dcs_pkg::A_DATA); apb(0, dcs_pkg::A_STAT);
    `CHK(rd[3:2], 2'b11)
    go(32'h40); fill(67); go(32'h40); apb(0, dcs_pkg::A_STAT);
    `CHK(rd[3:0], 4'h2)
    apb(0, 8'hFC);
    `CHK({err, rd}, 33'h100000000)
    $display("silo test done");
    drv_type_pin <= 1'($urandom);
    go(32'h40); go({27'h0, ~drv_type_pin, 4'h1}); apb(0, dcs_pkg::A_STAT);
    `CHK(rd[11], 1'b1)
    apb(0, dcs_pkg::A_DS);
    `CHK(rd[3], 1'b1)
    go(32'h40); go(32'h80); go({26'h1, drv_type_pin, 4'h1}); apb(0, dcs_pkg::A_DS);
    `CHK(rd[5:0], 6'h1F)
    apb(0, dcs_pkg::A_STAT);
    `CHK(rd[4:3], 2'b11)
    go(32'h40); apb(0, dcs_pkg::A_DS);
    `CHK({rd[2], rd[0]}, 2'b11)
    go({27'h0, drv_type_pin, 4'h1}); apb(0, dcs_pkg::A_DS);
    `CHK(rd[3:0], 4'hF)
    apb(0, dcs_pkg::A_STAT);
    `CHK(rd[4], 1'b0)
    go(32'h80); apb(0, dcs_pkg::A_DS);
    `CHK(rd[0], 1'b0)
    $display("drive status test done");
    for (k = 3; k < 9; k++) begin
      go(32'h40); go(32'h80);
      apb(1, dcs_pkg::A_DA, k < 8 ? k << 5 : (dcs_pkg::MAX_CYL + 1) << 8);
      go({27'h0, drv_type_pin, 4'h5}); apb(0, dcs_pkg::A_STAT);
      `CHK(rd[10], 1'b1)
      apb(0, dcs_pkg::A_DS);
      if (k < 8) `CHK(rd[5], k == 3 || k == 7)
    end
    go(32'h40); go(32'h80); apb(1, dcs_pkg::A_DA, 0); irqs = 0;
    go({27'h0, drv_type_pin, 4'h5});
    repeat (dcs_pkg::SEEK_CYC + 100) @(posedge mclk);
    `CHK(irqs, 1)
    irqs = 0; apb(1, dcs_pkg::A_CMD, {27'h0, drv_type_pin, 4'h3});
    while (irqs < 1) @(posedge mclk);
    apb(0, dcs_pkg::A_DS);
    `CHK(rd[3], 1'b1)
    while (irqs < 2) @(posedge mclk);
    apb(0, dcs_pkg::A_DS);
    `CHK(rd[3], 1'b0)
    go({27'h0, drv_type_pin, 4'h1}); apb(0, dcs_pkg::A_DS);
    `CHK(rd[3], 1'b1)
    $display("seek test done");
    go(32'h40); go(32'h80);
    for (i = 0; i < 257; i++) i_dcs_mem_disk.mem[32'h1000 + 2 * i] = 16'($urandom);
    xfer(32'h1000, 103, 4); xfer(32'h2000, 256, 3);
    for (i = 0; i < 256; i++)
      `CHK(i_dcs_mem_disk.mem[32'h2000 + 2 * i], i < 103 ? i_dcs_mem_disk.mem[32'h1000 + 2 * i] : 16'h0)
    k = $urandom % 103;
    i_dcs_mem_disk.mem[32'h2000 + 2 * k] = ~i_dcs_mem_disk.mem[32'h2000 + 2 * k];
    xfer(32'h2000, 103, 5);
    `CHK(rd[6], 1'b1)
    apb(0, dcs_pkg::A_BA);
    `CHK(rd[21:0], 22'(32'h2000 + 2 * k))
    apb(0, dcs_pkg::A_WC);
    `CHK(rd[15:0], 16'(103 - k))
    go(32'h40); xfer(32'h2000, k, 5);
    `CHK(rd[6], 1'b0)
    for (i = 3; i < 5; i++) begin
      go(32'h40); xfer(32'o776000, 1, i);
      `CHK(rd[7], 1'b1)
    end
    go(32'h40); xfer(32'h1000, 257, 4); go(32'h40); xfer(32'h3000, 512, 3, 1);
    `CHK(rd[5], 1'b1)
    for (i = 256; i < 512; i++)
      `CHK(i_dcs_mem_disk.mem[32'h3000 + 2 * i], i > 256 ? 16'h0 : i_dcs_mem_disk.mem[32'h1200])
    for (i = 0; i < 3; i++) begin
      go(32'h40);
      xfer(32'h4000, 512, 3 + (i + 1) % 3, 0, dcs_pkg::MAX_CYL << 8 | dcs_pkg::HEADS - 1 << 5 | dcs_pkg::SECTORS - 1);
      `CHK(rd[8], 1'b1)
    end
    go(32'h40); apb(1, dcs_pkg::A_WC, 200); apb(1, dcs_pkg::A_DA, 312 << 8); apb(1, dcs_pkg::A_CMD, 9);
    go(32'h40); xfer(32'h5000, 1, 3);
    `CHK(rd[9], 1'b1)
    $display("transfer test done");
    test_done;
  end
endmodule
